// File: design/abm_pkg.sv
// Package of constants and types for the address breakpoint matcher
package abm_pkg;

  // Bus and structure widths
  localparam int DATA_W = 32;
  localparam int ADDR_W = 5;
  localparam int NUM_BP = 4;

  // Register offsets (byte addresses, one aligned word each)
  localparam logic [ADDR_W-1:0] OFS_BP_BASE = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_BP_STRIDE = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_CTRL = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h14;
  localparam logic [ADDR_W-1:0] OFS_MASK = 5'h18;
  localparam logic [ADDR_W-1:0] OFS_EXT = 5'h1C;

  // Debug control register layout: local enable at 2n, all-task enable at 2n+1
  localparam int LOCAL_EN_LSB = 0;
  localparam int GLOBAL_EN_LSB = 1;
  localparam int EN_STRIDE = 2;
  localparam int TYPE_LSB = 16;
  localparam int SPAN_LSB = 18;
  localparam int FIELD_STRIDE = 4;
  localparam int EXT_DE_BIT = 0;

  // Writable bits, fixed-one bits and reset value of the control register
  localparam logic [DATA_W-1:0] CTRL_WMASK = 32'hFFFF_00FF;
  localparam logic [DATA_W-1:0] CTRL_FIXED = 32'h0000_0400;
  localparam logic [DATA_W-1:0] CTRL_RST = 32'h0000_0400;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h0000_0000;
  localparam logic [NUM_BP-1:0] FLAGS_ZERO = 4'h0;

  // Access-type field encoding
  typedef enum logic [1:0] {
    RW_EXEC = 2'h0,
    RW_WRITE = 2'h1,
    RW_IO = 2'h2,
    RW_DATA = 2'h3
  } abm_rw_type;

  // Match-span field encoding
  typedef enum logic [1:0] {
    SPAN_1 = 2'h0,
    SPAN_2 = 2'h1,
    SPAN_8 = 2'h2,
    SPAN_4 = 2'h3
  } abm_span_type;

  // Kind of access presented by the core
  typedef enum logic [1:0] {
    ACC_FETCH = 2'h0,
    ACC_READ = 2'h1,
    ACC_WRITE = 2'h2,
    ACC_IO = 2'h3
  } abm_kind_type;

  // Access size code: 1, 2, 4 or 8 bytes
  typedef enum logic [1:0] {
    SZ_1 = 2'h0,
    SZ_2 = 2'h1,
    SZ_4 = 2'h2,
    SZ_8 = 2'h3
  } abm_size_type;

  // Low address bits ignored for a given span
  function automatic logic [DATA_W-1:0] span_mask(input logic [1:0] span);
    logic [DATA_W-1:0] m;
    m = 32'h0000_0000;
    case (span)
      SPAN_2: m = 32'h0000_0001;
      SPAN_4: m = 32'h0000_0003;
      SPAN_8: m = 32'h0000_0007;
      default: m = 32'h0000_0000;
    endcase
    return m;
  endfunction : span_mask

  // Offset of the last byte touched by an access of a given size
  function automatic logic [DATA_W-1:0] size_last(input logic [1:0] size);
    logic [DATA_W-1:0] m;
    m = 32'h0000_0000;
    case (size)
      SZ_2: m = 32'h0000_0001;
      SZ_4: m = 32'h0000_0003;
      SZ_8: m = 32'h0000_0007;
      default: m = 32'h0000_0000;
    endcase
    return m;
  endfunction : size_last

endpackage : abm_pkg

// File: design/abm_match.sv
// Address breakpoint matcher: four comparators, control registers, interrupt
`timescale 1ns/100ps

// Contract
// - Four breakpoint address registers hold the addresses that accesses are compared against.
// - The debug control register holds per-register enables, access-type and span fields.
// - A local enable arms its comparator for the current task and is cleared on a task switch.
// - An all-task enable arms its comparator for every task and only software changes it.
// - A match triggers only when the access kind agrees with the access-type field.
// - The span field masks low stored address bits out of the comparison.
// - A hit is signalled when any byte of a multi-byte access falls inside the span.
// - Span code 11 selects four bytes, so address F004 covers F004 through F007.
// - Span code 10 selects eight bytes by ignoring the low three stored address bits.
// - Type 00 is execution, 01 data write, 11 data read or write, 10 I/O only with extensions on.
// - Span 00 is one byte, 01 two bytes, 11 four bytes and 10 eight bytes.
module abm_match
  import abm_pkg::*;
(
  input wire logic ref_clk_i,                 // Core clock, 20 MHz
  input wire logic reset_i,                   // Synchronous reset, active high
  input wire logic [ADDR_W-1:0] reg_addr_i,   // Register byte address
  input wire logic [DATA_W-1:0] reg_wdata_i,  // Register write data
  input wire logic reg_wr_i,                  // Register write strobe
  input wire logic reg_rd_i,                  // Register read strobe
  output logic [DATA_W-1:0] reg_rdata_o,      // Read data, cycle after strobe
  input wire logic acc_valid_i,               // Core access present this cycle
  input wire logic [DATA_W-1:0] acc_addr_i,   // First byte address of access
  input wire logic [1:0] acc_size_i,          // Size code, abm_size_type
  input wire logic [1:0] acc_kind_i,          // Kind code, abm_kind_type
  input wire logic task_switch_i,             // One-cycle task switch pulse
  output logic [NUM_BP-1:0] match_o,          // Per-comparator hit pulse
  output logic debug_exception_o,             // Any hit, one-cycle pulse
  output logic irq_o                          // Level, unmasked status set
);

  logic [DATA_W-1:0] bp_addr_r [NUM_BP];
  logic [DATA_W-1:0] ctrl_r;
  logic [DATA_W-1:0] ctrl_nxt;
  logic debug_extension_enable_r;
  logic [NUM_BP-1:0] status_r;
  logic [NUM_BP-1:0] mask_r;
  logic [NUM_BP-1:0] hit_vec;
  logic [NUM_BP-1:0] match_r;
  logic debug_exception_r;
  logic [DATA_W-1:0] rdata_r;
  logic [DATA_W-1:0] rdata_nxt;
  logic [NUM_BP-1:0] local_clr;
  logic [DATA_W:0] acc_end;

  // Last byte touched; one extra bit so an access near the top cannot wrap
  assign acc_end = {1'b0, acc_addr_i} + {1'b0, size_last(acc_size_i)};

  // One comparator per breakpoint register, all evaluated in parallel
  for (genvar g = 0; g < NUM_BP; g++) begin : g_cmp
    logic [1:0] type_f;
    logic [1:0] span_f;
    logic armed;
    logic type_ok;
    logic [DATA_W-1:0] lo;
    logic [DATA_W-1:0] hi;
    logic overlap;

    assign type_f = ctrl_r[TYPE_LSB + FIELD_STRIDE*g +: 2];
    assign span_f = ctrl_r[SPAN_LSB + FIELD_STRIDE*g +: 2];
    // Either enable arms it
    assign armed = ctrl_r[LOCAL_EN_LSB + EN_STRIDE*g] | ctrl_r[GLOBAL_EN_LSB + EN_STRIDE*g];

    // Span masks the stored address; a misaligned address folds to its block
    assign lo = bp_addr_r[g] & ~span_mask(span_f);
    assign hi = lo | span_mask(span_f);

    // Any byte of the access inside the window counts
    assign overlap = ({1'b0, acc_addr_i} <= {1'b0, hi}) && (acc_end >= {1'b0, lo});

    // Access kind against type field; I/O type dead without extensions
    always_comb begin
      type_ok = 1'b0;
      case (type_f)
        RW_EXEC: type_ok = (acc_kind_i == ACC_FETCH);
        RW_WRITE: type_ok = (acc_kind_i == ACC_WRITE);
        RW_IO: type_ok = debug_extension_enable_r && (acc_kind_i == ACC_IO);
        RW_DATA: type_ok = (acc_kind_i == ACC_READ) || (acc_kind_i == ACC_WRITE);
        default: type_ok = 1'b0;
      endcase
    end

    // Independent hit per comparator
    assign hit_vec[g] = acc_valid_i & armed & type_ok & overlap;
    assign local_clr[g] = task_switch_i;
  end

  // Breakpoint address registers
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      for (int i = 0; i < NUM_BP; i++) begin
        bp_addr_r[i] <= WORD_ZERO;
      end
    end else if (reg_wr_i) begin
      for (int i = 0; i < NUM_BP; i++) begin
        if (reg_addr_i == OFS_BP_BASE + ADDR_W'(i) * OFS_BP_STRIDE) begin
          bp_addr_r[i] <= reg_wdata_i;
        end
      end
    end
  end

  // Next control value: software write, then hardware clear of local enables
  always_comb begin
    ctrl_nxt = ctrl_r;
    if (reg_wr_i && reg_addr_i == OFS_CTRL) begin
      ctrl_nxt = (reg_wdata_i & CTRL_WMASK) | CTRL_FIXED;
    end
    // A task switch drops only local enables; global ones stay
    for (int i = 0; i < NUM_BP; i++) begin
      if (local_clr[i]) begin
        ctrl_nxt[LOCAL_EN_LSB + EN_STRIDE*i] = 1'b0;
      end
    end
  end

  // Debug control register
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      ctrl_r <= CTRL_RST;
    end else begin
      ctrl_r <= ctrl_nxt;
    end
  end

  // Extension control: I/O breakpoints only work with this set
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      debug_extension_enable_r <= 1'b0;
    end else if (reg_wr_i && reg_addr_i == OFS_EXT) begin
      debug_extension_enable_r <= reg_wdata_i[EXT_DE_BIT];
    end
  end

  // Hit outputs are registered so the core sees a clean pulse
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      match_r <= FLAGS_ZERO;
      debug_exception_r <= 1'b0;
    end else begin
      match_r <= hit_vec;
      debug_exception_r <= |hit_vec;
    end
  end

  // Sticky status, write one to clear; a new hit wins over the clear
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      status_r <= FLAGS_ZERO;
    end else if (reg_wr_i && reg_addr_i == OFS_STATUS) begin
      status_r <= (status_r & ~reg_wdata_i[NUM_BP-1:0]) | hit_vec;
    end else begin
      status_r <= status_r | hit_vec;
    end
  end

  // Interrupt mask
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      mask_r <= FLAGS_ZERO;
    end else if (reg_wr_i && reg_addr_i == OFS_MASK) begin
      mask_r <= reg_wdata_i[NUM_BP-1:0];
    end
  end

  // Read mux; unmapped addresses read zero
  always_comb begin
    rdata_nxt = WORD_ZERO;
    case (reg_addr_i)
      OFS_CTRL: rdata_nxt = ctrl_r;
      OFS_STATUS: rdata_nxt = {{(DATA_W-NUM_BP){1'b0}}, status_r};
      OFS_MASK: rdata_nxt = {{(DATA_W-NUM_BP){1'b0}}, mask_r};
      OFS_EXT: rdata_nxt = {{(DATA_W-1){1'b0}}, debug_extension_enable_r};
      default: begin
        for (int i = 0; i < NUM_BP; i++) begin
          if (reg_addr_i == OFS_BP_BASE + ADDR_W'(i) * OFS_BP_STRIDE) begin
            rdata_nxt = bp_addr_r[i];
          end
        end
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (reset_i) begin
      rdata_r <= WORD_ZERO;
    end else if (reg_rd_i) begin
      rdata_r <= rdata_nxt;
    end else begin
      rdata_r <= WORD_ZERO;
    end
  end

  assign reg_rdata_o = rdata_r;
  assign match_o = match_r;
  assign debug_exception_o = debug_exception_r;
  assign irq_o = |(status_r & mask_r);

  // Checks on comparator 0 fields and whole-block behaviour
  logic [1:0] t0;
  logic [1:0] s0;
  logic arm0;
  assign t0 = ctrl_r[TYPE_LSB +: 2];
  assign s0 = ctrl_r[SPAN_LSB +: 2];
  assign arm0 = ctrl_r[LOCAL_EN_LSB] | ctrl_r[GLOBAL_EN_LSB];

  // Fields of comparators 1 to 3, so each comparator has checks of its own
  logic [1:0] t1;
  logic [1:0] s1;
  logic arm1;
  logic [1:0] t2;
  logic [1:0] s2;
  logic arm2;
  logic [1:0] t3;
  logic [1:0] s3;
  logic arm3;
  assign t1 = ctrl_r[TYPE_LSB + FIELD_STRIDE +: 2];
  assign s1 = ctrl_r[SPAN_LSB + FIELD_STRIDE +: 2];
  assign arm1 = ctrl_r[LOCAL_EN_LSB + EN_STRIDE] | ctrl_r[GLOBAL_EN_LSB + EN_STRIDE];
  assign t2 = ctrl_r[TYPE_LSB + FIELD_STRIDE*2 +: 2];
  assign s2 = ctrl_r[SPAN_LSB + FIELD_STRIDE*2 +: 2];
  assign arm2 = ctrl_r[LOCAL_EN_LSB + EN_STRIDE*2] | ctrl_r[GLOBAL_EN_LSB + EN_STRIDE*2];
  assign t3 = ctrl_r[TYPE_LSB + FIELD_STRIDE*3 +: 2];
  assign s3 = ctrl_r[SPAN_LSB + FIELD_STRIDE*3 +: 2];
  assign arm3 = ctrl_r[LOCAL_EN_LSB + EN_STRIDE*3] | ctrl_r[GLOBAL_EN_LSB + EN_STRIDE*3];

  a_local_cleared: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    task_switch_i |=> (ctrl_r[LOCAL_EN_LSB] == 1'b0)
      && (ctrl_r[LOCAL_EN_LSB + EN_STRIDE] == 1'b0)
      && (ctrl_r[LOCAL_EN_LSB + EN_STRIDE*2] == 1'b0)
      && (ctrl_r[LOCAL_EN_LSB + EN_STRIDE*3] == 1'b0))
    else $error("local enable survived a task switch");

  a_global_kept: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    task_switch_i && !(reg_wr_i && reg_addr_i == OFS_CTRL)
      |=> $stable(ctrl_r[GLOBAL_EN_LSB]) && $stable(ctrl_r[TYPE_LSB +: 2])
      && $stable(ctrl_r[GLOBAL_EN_LSB + EN_STRIDE*3]))
    else $error("task switch altered a global setting");

  a_unarmed_silent: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    !arm0 |=> !match_o[0])
    else $error("disabled comparator reported a hit");

  a_type_write_only: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    acc_valid_i && t1 == RW_WRITE && acc_kind_i != ACC_WRITE |=> !match_o[1])
    else $error("write-only breakpoint hit on other access");

  a_io_needs_ext: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    t2 == RW_IO && !debug_extension_enable_r |=> !match_o[2])
    else $error("I/O breakpoint hit with extensions off");

  a_io_ext_hit: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    acc_valid_i && arm2 && t2 == RW_IO && debug_extension_enable_r && acc_kind_i == ACC_IO
      && s2 == SPAN_1 && acc_size_i == SZ_1 && acc_addr_i == bp_addr_r[2]
      |=> match_o[2])
    else $error("I/O breakpoint missed with extensions on");

  a_one_byte_exact: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    acc_valid_i && s0 == SPAN_1 && acc_size_i == SZ_1 && acc_addr_i != bp_addr_r[0]
      |=> !match_o[0])
    else $error("one byte span hit on another address");

  a_four_byte_top: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    acc_valid_i && arm1 && t1 == RW_DATA && acc_kind_i == ACC_READ && s1 == SPAN_4
      && acc_size_i == SZ_1 && acc_addr_i == (bp_addr_r[1] | 32'h0000_0003)
      |=> match_o[1] && debug_exception_o)
    else $error("four byte span missed its last byte");

  a_eight_byte_fold: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    acc_valid_i && arm2 && t2 == RW_DATA && acc_kind_i == ACC_READ && s2 == SPAN_8
      && acc_size_i == SZ_1 && acc_addr_i[DATA_W-1:3] == bp_addr_r[2][DATA_W-1:3]
      |=> match_o[2])
    else $error("eight byte span missed a byte of its block");

  a_any_byte_hit: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    acc_valid_i && arm0 && t0 == RW_EXEC && acc_kind_i == ACC_FETCH && s0 == SPAN_1
      && acc_size_i == SZ_4 && bp_addr_r[0] > 32'h0000_0003
      && acc_addr_i == bp_addr_r[0] - 32'h0000_0003
      |=> match_o[0])
    else $error("hit on last byte of access missed");

  a_status_sticky: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    match_o[0] |-> status_r[0] ##1 (status_r[0] || $past(reg_wr_i)))
    else $error("status bit did not latch a hit");

  a_two_byte_pair: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    acc_valid_i && arm0 && t0 == RW_DATA && acc_kind_i == ACC_WRITE && s0 == SPAN_2
      && acc_size_i == SZ_1 && acc_addr_i == (bp_addr_r[0] | 32'h0000_0001)
      |=> match_o[0])
    else $error("two byte span missed its upper byte");

  a_fetch_type_only: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    acc_valid_i && t0 == RW_EXEC && acc_kind_i != ACC_FETCH |=> !match_o[0])
    else $error("execution breakpoint hit on a data access");

  a_data_type_hit: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    acc_valid_i && arm3 && t3 == RW_DATA && acc_kind_i == ACC_READ && s3 == SPAN_1
      && acc_size_i == SZ_1 && acc_addr_i == bp_addr_r[3]
      |=> match_o[3])
    else $error("data breakpoint missed a read");

  a_unarmed_rest: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    !arm1 && !arm2 && !arm3 |=> match_o[NUM_BP-1:1] == 3'h0)
    else $error("disabled upper comparator reported a hit");

  a_hit_sets_status: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    (|match_o) |-> (status_r & match_o) == match_o)
    else $error("hit left its status bit clear");

  a_bp_write_lands: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == OFS_BP_BASE |=> bp_addr_r[0] == $past(reg_wdata_i))
    else $error("breakpoint address write lost");

  a_ctrl_write_lands: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    reg_wr_i && reg_addr_i == OFS_CTRL && !task_switch_i
      |=> ctrl_r == (($past(reg_wdata_i) & CTRL_WMASK) | CTRL_FIXED))
    else $error("control write lost");

  a_read_idle: assert property (
    @(posedge ref_clk_i) disable iff (reset_i)
    !reg_rd_i |=> reg_rdata_o == WORD_ZERO)
    else $error("read data outside its cycle");

endmodule : abm_match

// File: tb/abm_core_model.sv
// Core access stream model driving the matcher's far side
`timescale 1ns/100ps
module abm_core_model
  import abm_pkg::*;
(
  input wire logic clk_i,                // Core clock
  output logic acc_valid_o,              // Access present
  output logic [DATA_W-1:0] acc_addr_o,  // First byte address
  output logic [1:0] acc_size_o,         // Size code
  output logic [1:0] acc_kind_o,         // Kind code
  output logic task_switch_o             // Task switch pulse
);
  // Idle values at time zero
  initial begin
    acc_valid_o = 1'b0;
    acc_addr_o = 32'h0000_0000;
    acc_size_o = 2'h0;
    acc_kind_o = 2'h0;
    task_switch_o = 1'b0;
  end

  // One access, one cycle; released lines flip so stale values cannot match
  task automatic access(input logic [DATA_W-1:0] a, input logic [1:0] s,
                        input logic [1:0] k);
    @(posedge clk_i);
    acc_valid_o <= 1'b1;
    acc_addr_o <= a;
    acc_size_o <= s;
    acc_kind_o <= k;
    @(posedge clk_i);
    acc_valid_o <= 1'b0;
    acc_addr_o <= ~a;
    acc_size_o <= ~s;
    acc_kind_o <= ~k;
    #1;
  endtask : access

  // Task switch pulse of one cycle
  task automatic switch_task();
    @(posedge clk_i);
    task_switch_o <= 1'b1;
    @(posedge clk_i);
    task_switch_o <= 1'b0;
    #1;
  endtask : switch_task
endmodule : abm_core_model

// File: tb/abm_match_bench.sv
// Self-checking bench for the address breakpoint matcher
`timescale 1ns/100ps
module abm_match_bench
  import abm_pkg::*;
;
  logic ref_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic [ADDR_W-1:0] reg_addr_i = 5'h00;
  logic [DATA_W-1:0] reg_wdata_i = 32'h0000_0000;
  logic reg_wr_i = 1'b0;
  logic reg_rd_i = 1'b0;
  logic [DATA_W-1:0] reg_rdata_o;
  logic acc_valid_i;
  logic [DATA_W-1:0] acc_addr_i;
  logic [1:0] acc_size_i;
  logic [1:0] acc_kind_i;
  logic task_switch_i;
  logic [NUM_BP-1:0] match_o;
  logic debug_exception_o;
  logic irq_o;
  int n_fail = 0;
  int check_count = 0;
  // Boundary accesses around the three programmed windows
  localparam logic [31:0] T_ADDR [7] = '{32'h0000_EFFB, 32'h0000_EFFE, 32'h0000_EFFE,
    32'h0000_F000, 32'h0000_F001, 32'h0000_F005, 32'h0000_F008};
  localparam logic [1:0] T_SIZE [7] = '{SZ_8, SZ_2, SZ_4, SZ_1, SZ_2, SZ_4, SZ_1};
  localparam logic [3:0] T_EXP [7] = '{4'h5, 4'h0, 4'h5, 4'h5, 4'h4, 4'h6, 4'h0};

  // 20 MHz clock
  always #25 ref_clk_i = ~ref_clk_i;

  abm_match dut (.ref_clk_i(ref_clk_i), .reset_i(reset_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .acc_valid_i(acc_valid_i), .acc_addr_i(acc_addr_i),
    .acc_size_i(acc_size_i), .acc_kind_i(acc_kind_i), .task_switch_i(task_switch_i),
    .match_o(match_o), .debug_exception_o(debug_exception_o), .irq_o(irq_o));

  abm_core_model core (.clk_i(ref_clk_i), .acc_valid_o(acc_valid_i),
    .acc_addr_o(acc_addr_i), .acc_size_o(acc_size_i), .acc_kind_o(acc_kind_i),
    .task_switch_o(task_switch_i));

  // Compare with case equality so unknowns count as wrong
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // One-cycle write strobe
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b1;
    reg_addr_i <= a;
    reg_wdata_i <= d;
    @(posedge ref_clk_i);
    reg_wr_i <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rdchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] exp);
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b1;
    reg_addr_i <= a;
    @(posedge ref_clk_i);
    reg_rd_i <= 1'b0;
    #1;
    chk("reg_rdata_o", exp, reg_rdata_o);
  endtask : rdchk

  // Access, then per-comparator hits and the exception one cycle later
  task automatic acc(input logic [31:0] a, input logic [1:0] s, input logic [1:0] k,
                     input logic [3:0] exp);
    core.access(a, s, k);
    chk("match_o", {28'h0, exp}, {28'h0, match_o});
    chk("debug_exception_o", {31'h0, |exp}, {31'h0, debug_exception_o});
  endtask : acc

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  // Watchdog well beyond the hundred or so cycles the tests need
  initial begin
    #(4000 * 50);
    n_fail++;
    final_report();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rdchk(OFS_CTRL, 32'h0000_0400);
    rdchk(OFS_STATUS, 32'h0000_0000);
    wr(5'h02, 32'hFFFF_FFFF);
    rdchk(5'h02, 32'h0000_0000);
    // Three windows: one byte, four bytes, eight bytes from an unaligned address
    wr(OFS_BP_BASE, 32'h0000_F000);
    wr(OFS_BP_BASE + OFS_BP_STRIDE, 32'h0000_F004);
    wr(OFS_BP_BASE + ADDR_W'(2) * OFS_BP_STRIDE, 32'h0000_F005);
    rdchk(OFS_BP_BASE + OFS_BP_STRIDE, 32'h0000_F004);
    wr(OFS_CTRL, 32'h0BF3_002A);
    rdchk(OFS_CTRL, 32'h0BF3_042A);
    for (int i = 0; i < 7; i++) begin
      acc(T_ADDR[i], T_SIZE[i], ACC_READ, T_EXP[i]);
    end
    acc(32'h0000_F007, SZ_1, ACC_READ, 4'h6);
    // Sticky status, mask and level interrupt
    rdchk(OFS_STATUS, 32'h0000_0007);
    chk("irq_o", 32'h0, {31'h0, irq_o});
    wr(OFS_MASK, 32'h0000_0001);
    #1;
    chk("irq_o", 32'h1, {31'h0, irq_o});
    wr(OFS_STATUS, 32'h0000_0001);
    #1;
    chk("irq_o", 32'h0, {31'h0, irq_o});
    rdchk(OFS_STATUS, 32'h0000_0006);
    // Access types: exec, write, I/O, data on one byte at F000
    for (int i = 0; i < 4; i++) begin
      wr(OFS_BP_BASE + ADDR_W'(i) * OFS_BP_STRIDE, 32'h0000_F000);
    end
    wr(OFS_CTRL, 32'h3210_00AA);
    acc(32'h0000_F000, SZ_1, ACC_FETCH, 4'h1);
    acc(32'h0000_EFFD, SZ_4, ACC_FETCH, 4'h1);
    acc(32'h0000_F000, SZ_1, ACC_READ, 4'h8);
    acc(32'h0000_F000, SZ_1, ACC_WRITE, 4'hA);
    acc(32'h0000_F000, SZ_1, ACC_IO, 4'h0);
    wr(OFS_EXT, 32'h0000_0001);
    acc(32'h0000_F000, SZ_1, ACC_IO, 4'h4);
    // Local enable on one, all-task enable on another, then a task switch
    wr(OFS_CTRL, 32'h3210_0084);
    acc(32'h0000_F000, SZ_2, ACC_WRITE, 4'hA);
    core.switch_task();
    rdchk(OFS_CTRL, 32'h3210_0480);
    acc(32'h0000_F000, SZ_2, ACC_WRITE, 4'h8);
    // Two-byte span on comparator 0 alone
    wr(OFS_BP_BASE, 32'h0000_F002);
    wr(OFS_CTRL, 32'h0007_0002);
    acc(32'h0000_F001, SZ_2, ACC_READ, 4'h1);
    acc(32'h0000_F003, SZ_1, ACC_WRITE, 4'h1);
    acc(32'h0000_F004, SZ_1, ACC_WRITE, 4'h0);
    // Reset in mid-run brings every register back to its reset value
    @(posedge ref_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge ref_clk_i);
    reset_i <= 1'b0;
    rdchk(OFS_CTRL, 32'h0000_0400);
    rdchk(OFS_BP_BASE, 32'h0000_0000);
    rdchk(OFS_STATUS, 32'h0000_0000);
    rdchk(OFS_MASK, 32'h0000_0000);
    rdchk(OFS_EXT, 32'h0000_0000);
    chk("irq_o", 32'h0, {31'h0, irq_o});
    final_report();
  end
endmodule : abm_match_bench
